// File: core/psc_mode_dec.sv
`timescale 1ns/1ns
// Privilege mode decode and address region check
module psc_mode_dec
  import psc_pkg::*;
(
  // Status bits and debug flag
  input wire logic exception_level_i,
  input wire logic error_level_i,
  input wire logic debug_mode_flag_i,
  input wire logic [1:0] user_field_i,
  // Address to check
  input wire logic [31:0] addr_i,
  // Decoded results
  output psc_mode_e mode_o,
  output logic addr_ok_o
);

  // True for the mapped user segment (lower half of space)
  function automatic logic in_user_seg(input logic [31:0] a);
    in_user_seg = ~a[31];
  endfunction : in_user_seg

  // True for the upper half of mapped kernel segment two
  function automatic logic in_upper_seg(input logic [31:0] a);
    in_upper_seg = (a[31:29] == SEG_UPPER_TOP);
  endfunction : in_upper_seg

  // Mode from current bits only, so a write acts next cycle
  always_comb begin
    if (debug_mode_flag_i) begin
      mode_o = PSC_MODE_DEBUG;
    end else if (exception_level_i || error_level_i ||
                 user_field_i == USF_KERNEL) begin
      mode_o = PSC_MODE_KERNEL;
    end else if (user_field_i == USF_USER) begin
      mode_o = PSC_MODE_USER;
    end else if (user_field_i == USF_SUPER) begin
      mode_o = PSC_MODE_SUPER;
    end else begin
      // Field value 3 is undefined; treat as user, the safer side
      mode_o = PSC_MODE_USER;
    end
  end

  // Region reach per mode
  always_comb begin
    case (mode_o)
      PSC_MODE_USER: addr_ok_o = in_user_seg(addr_i);
      PSC_MODE_SUPER: begin
        addr_ok_o = in_user_seg(addr_i) | in_upper_seg(addr_i);
      end
      PSC_MODE_KERNEL: addr_ok_o = 1'b1;
      PSC_MODE_DEBUG: addr_ok_o = 1'b1;
      default: addr_ok_o = 1'b0;
    endcase
  end

endmodule : psc_mode_dec

// File: core/psc_pkg.sv
// Notes on behaviour
// - Interrupts enabled: enable set, levels clear, no debug
// - Mask field bits 15:8 gates eight lines
// - User mode: levels clear, no debug, field 2
// - User mode reaches only mapped user segment
// - Supervisor mode: levels clear, no debug, field 1
// - Supervisor: user segment and upper segment, no system control
// - Kernel: no debug and any level or field 0
// - Kernel reaches everything except debug resources
// - Kernel at reset and events; left when conditions clear
// - Debug flag set gives debug mode, everything
// - Unusable coprocessor access raises an exception
// - Bit 31 hardwired zero, read only
// - Bit 30 read only, reads zero
// - Bit 29 gates floating-point unit access
package psc_pkg;

  // Field positions of the status and control register
  localparam int unsigned POS_COP3_USABLE = 31;
  localparam int unsigned POS_COP2_USABLE = 30;
  localparam int unsigned POS_FPU_USABLE = 29;
  localparam int unsigned POS_DSP_ENABLE = 24;
  localparam int unsigned POS_IRQ_MASK_HI = 15;
  localparam int unsigned POS_IRQ_MASK_LO = 8;
  localparam int unsigned POS_USER_SELECT = 4;
  localparam int unsigned POS_SUPER_SELECT = 3;
  localparam int unsigned POS_ERROR_LEVEL = 2;
  localparam int unsigned POS_EXC_LEVEL = 1;
  localparam int unsigned POS_GLOBAL_IE = 0;

  // Bits that software can write; all others read as zero
  localparam logic [31:0] STATUS_WR_MASK = 32'h2100_ff1f;
  // Reset value: error level set so the core starts in kernel mode
  localparam logic [31:0] STATUS_RESET = 32'h0000_0004;

  // User/supervisor field encodings
  localparam logic [1:0] USF_KERNEL = 2'h0;
  localparam logic [1:0] USF_SUPER = 2'h1;
  localparam logic [1:0] USF_USER = 2'h2;

  // Address segment boundaries, top three address bits
  localparam logic [2:0] SEG_UPPER_TOP = 3'h7;

  // Privilege modes, Gray coded along kernel-super-user-debug
  typedef enum logic [1:0] {
    PSC_MODE_KERNEL = 2'b00,
    PSC_MODE_SUPER = 2'b01,
    PSC_MODE_USER = 2'b11,
    PSC_MODE_DEBUG = 2'b10
  } psc_mode_e;

endpackage : psc_pkg

// File: core/psc_status.sv
`timescale 1ns/1ns
// Status and control register with interrupt and privilege decode
module psc_status
  import psc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // System control coprocessor register port
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wr_data_i,
  output logic [31:0] reg_rd_data_o,
  // Pipeline events
  input wire logic exc_entry_i,
  input wire logic err_entry_i,
  input wire logic eret_i,
  // Debug register mode flag
  input wire logic debug_mode_flag_i,
  // Interrupt lines
  input wire logic [7:0] irq_lines_i,
  output logic [7:0] irq_req_o,
  output logic global_int_enable_o,
  // Privilege mode and memory access check
  output logic [1:0] priv_mode_o,
  input wire logic mem_acc_i,
  input wire logic [31:0] mem_addr_i,
  output logic mem_deny_o,
  // Privileged resource requests
  input wire logic sysctl_acc_i,
  input wire logic dbg_res_acc_i,
  output logic priv_exc_o,
  // Coprocessor and extension requests
  input wire logic cop1_acc_i,
  input wire logic cop2_acc_i,
  input wire logic cop3_acc_i,
  input wire logic dsp_acc_i,
  output logic cop_unusable_exc_o,
  output logic dsp_disabled_exc_o
);

  // Stored fields
  logic global_int_enable_ff; // Global enable
  logic exception_level_ff; // Exception level
  logic error_level_ff; // Error level
  logic user_select_ff; // Upper bit of user/supervisor field
  logic supervisor_select_ff; // Lower bit of that field
  logic [7:0] irq_mask_ff; // Per-line mask
  logic fpu_usable_ff; // Floating-point unit usable
  logic dsp_access_enable_ff; // DSP extension enable
  // Next values
  logic nxt_global_int_enable;
  logic nxt_exception_level;
  logic nxt_error_level;
  logic nxt_user_select;
  logic nxt_supervisor_select;
  logic [7:0] nxt_irq_mask;
  logic nxt_fpu_usable;
  logic nxt_dsp_access_enable;
  // Decoded
  psc_mode_e mode; // Current privilege mode
  logic addr_ok; // Address reachable in this mode
  logic int_en; // Interrupts globally enabled

  // Next register values: software write, then hardware events
  always_comb begin
    nxt_global_int_enable = global_int_enable_ff;
    nxt_exception_level = exception_level_ff;
    nxt_error_level = error_level_ff;
    nxt_user_select = user_select_ff;
    nxt_supervisor_select = supervisor_select_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_fpu_usable = fpu_usable_ff;
    nxt_dsp_access_enable = dsp_access_enable_ff;
    if (reg_wr_i) begin
      nxt_global_int_enable = reg_wr_data_i[POS_GLOBAL_IE];
      nxt_exception_level = reg_wr_data_i[POS_EXC_LEVEL];
      nxt_error_level = reg_wr_data_i[POS_ERROR_LEVEL];
      nxt_user_select = reg_wr_data_i[POS_USER_SELECT];
      nxt_supervisor_select = reg_wr_data_i[POS_SUPER_SELECT];
      nxt_irq_mask = reg_wr_data_i[POS_IRQ_MASK_HI:POS_IRQ_MASK_LO];
      nxt_fpu_usable = reg_wr_data_i[POS_FPU_USABLE];
      nxt_dsp_access_enable = reg_wr_data_i[POS_DSP_ENABLE];
    end
    // Return clears error level first, else exception level
    if (eret_i) begin
      if (error_level_ff) begin
        nxt_error_level = 1'b0;
      end else begin
        nxt_exception_level = 1'b0;
      end
    end
    // Entry events win over write and return in the same cycle
    if (exc_entry_i) begin
      nxt_exception_level = 1'b1;
    end
    if (err_entry_i) begin
      nxt_error_level = 1'b1;
    end
  end

  // Register stage; reset lands in kernel mode
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      global_int_enable_ff <= STATUS_RESET[POS_GLOBAL_IE];
      exception_level_ff <= STATUS_RESET[POS_EXC_LEVEL];
      error_level_ff <= STATUS_RESET[POS_ERROR_LEVEL];
      user_select_ff <= STATUS_RESET[POS_USER_SELECT];
      supervisor_select_ff <= STATUS_RESET[POS_SUPER_SELECT];
      irq_mask_ff <= STATUS_RESET[POS_IRQ_MASK_HI:POS_IRQ_MASK_LO];
      fpu_usable_ff <= STATUS_RESET[POS_FPU_USABLE];
      dsp_access_enable_ff <= STATUS_RESET[POS_DSP_ENABLE];
    end else begin
      global_int_enable_ff <= nxt_global_int_enable;
      exception_level_ff <= nxt_exception_level;
      error_level_ff <= nxt_error_level;
      user_select_ff <= nxt_user_select;
      supervisor_select_ff <= nxt_supervisor_select;
      irq_mask_ff <= nxt_irq_mask;
      fpu_usable_ff <= nxt_fpu_usable;
      dsp_access_enable_ff <= nxt_dsp_access_enable;
    end
  end

  // Read view; unused bits and the two missing coprocessors read 0
  always_comb begin
    reg_rd_data_o = '0;
    reg_rd_data_o[POS_COP3_USABLE] = 1'b0;
    reg_rd_data_o[POS_COP2_USABLE] = 1'b0;
    reg_rd_data_o[POS_FPU_USABLE] = fpu_usable_ff;
    reg_rd_data_o[POS_DSP_ENABLE] = dsp_access_enable_ff;
    reg_rd_data_o[POS_IRQ_MASK_HI:POS_IRQ_MASK_LO] = irq_mask_ff;
    reg_rd_data_o[POS_USER_SELECT] = user_select_ff;
    reg_rd_data_o[POS_SUPER_SELECT] = supervisor_select_ff;
    reg_rd_data_o[POS_ERROR_LEVEL] = error_level_ff;
    reg_rd_data_o[POS_EXC_LEVEL] = exception_level_ff;
    reg_rd_data_o[POS_GLOBAL_IE] = global_int_enable_ff;
  end

  // Mode and region decode
  psc_mode_dec u_mode_dec (
    .exception_level_i(exception_level_ff),
    .error_level_i(error_level_ff),
    .debug_mode_flag_i(debug_mode_flag_i),
    .user_field_i({user_select_ff, supervisor_select_ff}),
    .addr_i(mem_addr_i),
    .mode_o(mode),
    .addr_ok_o(addr_ok)
  );

  // Interrupt enable and per-line gating
  always_comb begin
    int_en = global_int_enable_ff & ~exception_level_ff &
             ~error_level_ff & ~debug_mode_flag_i;
    irq_req_o = int_en ? (irq_lines_i & irq_mask_ff) : 8'h00;
  end

  // Access checks and exception requests
  always_comb begin
    mem_deny_o = mem_acc_i & ~addr_ok;
    // System control needs kernel or debug; debug port needs debug
    priv_exc_o = (sysctl_acc_i & (mode == PSC_MODE_USER ||
                  mode == PSC_MODE_SUPER)) |
                 (dbg_res_acc_i & (mode != PSC_MODE_DEBUG));
    cop_unusable_exc_o = (cop1_acc_i & ~fpu_usable_ff) |
                         cop2_acc_i | cop3_acc_i;
    dsp_disabled_exc_o = dsp_acc_i & ~dsp_access_enable_ff;
  end

  assign global_int_enable_o = int_en;
  assign priv_mode_o = mode;

  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_int_enable_cond: assert property (
    global_int_enable_o == ($past(nxt_global_int_enable) &
      ~$past(nxt_exception_level) & ~$past(nxt_error_level) &
      ~debug_mode_flag_i))
    else $error("global interrupt enable decode wrong");

  a_irq_gating: assert property (
    irq_req_o == (global_int_enable_o ?
      (irq_lines_i & reg_rd_data_o[15:8]) : 8'h00))
    else $error("interrupt line gating wrong");

  a_user_mode: assert property (
    (!debug_mode_flag_i && reg_rd_data_o[4:1] == 4'h8)
      |-> priv_mode_o == PSC_MODE_USER)
    else $error("user mode not decoded");

  a_user_reach: assert property (
    (priv_mode_o == PSC_MODE_USER && mem_acc_i)
      |-> mem_deny_o == mem_addr_i[31])
    else $error("user access check wrong");

  a_super_mode: assert property (
    (!debug_mode_flag_i && reg_rd_data_o[4:1] == 4'h4)
      |-> priv_mode_o == PSC_MODE_SUPER)
    else $error("supervisor mode not decoded");

  a_super_sysctl: assert property (
    (priv_mode_o == PSC_MODE_SUPER && sysctl_acc_i) |-> priv_exc_o)
    else $error("supervisor reached system control");

  a_kernel_mode: assert property (
    (!debug_mode_flag_i && (reg_rd_data_o[2:1] != 2'h0 ||
      reg_rd_data_o[4:3] == USF_KERNEL))
      |-> priv_mode_o == PSC_MODE_KERNEL)
    else $error("kernel mode not decoded");

  a_kernel_reach: assert property (
    (priv_mode_o == PSC_MODE_KERNEL) |-> !mem_deny_o &&
      (priv_exc_o == dbg_res_acc_i))
    else $error("kernel reach wrong");

  a_exc_entry: assert property (
    exc_entry_i |=> reg_rd_data_o[POS_EXC_LEVEL] &&
      (debug_mode_flag_i || priv_mode_o == PSC_MODE_KERNEL))
    else $error("exception entry did not give kernel mode");

  a_debug_mode: assert property (
    debug_mode_flag_i |-> priv_mode_o == PSC_MODE_DEBUG &&
      !mem_deny_o && !(dbg_res_acc_i && !sysctl_acc_i && priv_exc_o))
    else $error("debug mode wrong");

  a_cop_unusable: assert property (
    (cop2_acc_i || cop3_acc_i) |-> cop_unusable_exc_o)
    else $error("missing coprocessor not trapped");

  a_cop_hard_zero: assert property (
    reg_rd_data_o[31:30] == 2'b00)
    else $error("coprocessor 3 or 2 bit not zero");

  a_fpu_write: assert property (
    reg_wr_i ##1 (cop1_acc_i && !cop2_acc_i && !cop3_acc_i)
      |-> cop_unusable_exc_o == !$past(reg_wr_data_i[29]))
    else $error("fpu usable write not honoured");

  a_dsp_gate: assert property (
    reg_wr_i ##1 dsp_acc_i
      |-> dsp_disabled_exc_o == !$past(reg_wr_data_i[24]))
    else $error("dsp enable write not honoured");

endmodule : psc_status

// File: tb/tb.sv
`timescale 1ns/1ns
// Random self-checking bench for the status and control register
module tb;
  import psc_pkg::*;

  // Stimulus towards the design
  logic ref_clk_i, rst_i, reg_wr_i, exc_entry_i, err_entry_i, eret_i;
  logic [31:0] reg_wr_data_i, mem_addr_i;
  logic debug_mode_flag_i, mem_acc_i, sysctl_acc_i, dbg_res_acc_i;
  logic cop1_acc_i, cop2_acc_i, cop3_acc_i, dsp_acc_i;
  logic [7:0] irq_lines_i;
  // Observed outputs
  logic [31:0] reg_rd_data_o;
  logic [7:0] irq_req_o;
  logic [1:0] priv_mode_o;
  logic global_int_enable_o, mem_deny_o, priv_exc_o;
  logic cop_unusable_exc_o, dsp_disabled_exc_o;
  // Counters and the register model
  int fail_count, checks, r;
  bit [31:0] st;

  psc_status psc_status_inst (
    .ref_clk_i, .rst_i, .reg_wr_i, .reg_wr_data_i, .reg_rd_data_o,
    .exc_entry_i, .err_entry_i, .eret_i, .debug_mode_flag_i,
    .irq_lines_i, .irq_req_o, .global_int_enable_o, .priv_mode_o,
    .mem_acc_i, .mem_addr_i, .mem_deny_o, .sysctl_acc_i,
    .dbg_res_acc_i, .priv_exc_o, .cop1_acc_i, .cop2_acc_i,
    .cop3_acc_i, .dsp_acc_i, .cop_unusable_exc_o, .dsp_disabled_exc_o
  );

  // Free running 100 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // One comparison, counted; a mismatch is reported at once
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Expected decodes from the model state and the current inputs
  task automatic expect_all();
    bit lv;
    bit ok;
    bit gie;
    bit [1:0] md;
    bit pe;
    bit ce;
    lv = st[1] | st[2];
    if (debug_mode_flag_i) md = 2'b10;
    else if (lv || st[4:3] == 2'h0) md = 2'b00;
    else if (st[4:3] == 2'h1) md = 2'b01;
    else md = 2'b11;
    gie = st[0] && !lv && !debug_mode_flag_i;
    // Kernel and debug reach all; user low half; super adds top eighth
    ok = !md[0] || !mem_addr_i[31] ||
      (md == 2'b01 && mem_addr_i[31:29] == 3'h7);
    check("rd_data", reg_rd_data_o, st);
    check("int_enable", global_int_enable_o, gie);
    check("irq_req", irq_req_o, gie ? irq_lines_i & st[15:8] : 0);
    check("mode", priv_mode_o, md);
    check("mem_deny", mem_deny_o, mem_acc_i && !ok);
    // Privilege traps expected from the model mode, coprocessor traps from the model state
    pe = (sysctl_acc_i && md[0]) || (dbg_res_acc_i && md != 2'b10);
    ce = (cop1_acc_i && !st[29]) || cop2_acc_i || cop3_acc_i;
    check("priv_exc", priv_exc_o, pe);
    check("cop_exc", cop_unusable_exc_o, ce);
    check("dsp_exc", dsp_disabled_exc_o, dsp_acc_i && !st[24]);
  endtask : expect_all

  // Register update at a rising edge: entries, then return, then write
  task automatic step_model();
    if (exc_entry_i || err_entry_i) begin
      st[1] = st[1] | exc_entry_i;
      st[2] = st[2] | err_entry_i;
    end else if (eret_i) begin
      if (st[2]) st[2] = 1'b0;
      else st[1] = 1'b0;
    end else if (reg_wr_i) begin
      st = reg_wr_data_i & STATUS_WR_MASK;
    end
  endtask : step_model

  // At most one write or event per cycle, random everything else
  task automatic drive_random();
    r = $urandom_range(7);
    reg_wr_i = (r < 3);
    exc_entry_i = (r == 3);
    err_entry_i = (r == 4);
    eret_i = (r > 4);
    reg_wr_data_i = $urandom;
    mem_addr_i = $urandom;
    if ($urandom_range(15) == 0) debug_mode_flag_i = ~debug_mode_flag_i;
    {irq_lines_i, mem_acc_i, sysctl_acc_i, dbg_res_acc_i, cop1_acc_i,
      cop2_acc_i, cop3_acc_i, dsp_acc_i} = 15'($urandom);
  endtask : drive_random

  // Reset held for 20 cycles with the strobes quiet
  task automatic do_reset();
    #1;
    {reg_wr_i, exc_entry_i, err_entry_i, eret_i} = 4'h0;
    rst_i = 1'b1;
    st = 32'h0000_0004;
    repeat (20) @(negedge ref_clk_i);
    #1 expect_all();
    rst_i = 1'b0;
  endtask : do_reset

  // Main sequence, with a second reset in mid-run
  initial begin
    {rst_i, reg_wr_i, exc_entry_i, err_entry_i, eret_i} = 5'h10;
    {reg_wr_data_i, mem_addr_i, irq_lines_i} = '0;
    {debug_mode_flag_i, mem_acc_i, sysctl_acc_i, dbg_res_acc_i} = 4'h0;
    {cop1_acc_i, cop2_acc_i, cop3_acc_i, dsp_acc_i} = 4'h0;
    fail_count = 0;
    checks = 0;
    r = $urandom(32'hd9d8);
    do_reset();
    for (int i = 0; i < 4000; i++) begin
      @(negedge ref_clk_i);
      drive_random();
      #1 expect_all();
      @(posedge ref_clk_i);
      step_model();
      if (i == 2000) do_reset();
    end
    tally_and_finish();
  end

  // Watchdog: the run needs about 40 us
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end

endmodule : tb
